// *** logic/ifp_programmer.sv ***
// APB register block and command sequencer of the in-application flash programmer.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ifp_programmer
   import ifp_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output var  logic [31:0]    prdata,
   output var  logic           pready,
   output var  logic           pslverr,
   input  wire logic [1:0]     programmable_region_limit,
   input  wire logic           running_loader,
   input  wire logic           flash_done,
   output var  logic           flash_req,
   output var  ifp_flash_cmd_t flash_cmd,
   output var  logic           cpu_stall,
   output var  logic [1:0]     code_read_map,
   output var  logic           boot_from_loader
);

   // ************************************************************
   // Functions
   // ************************************************************

   // True when a write or erase may touch the given region and address.
   function automatic logic ifp_allowed(input logic [7:0] rgn, input logic [15:0] a,
                                        input logic [1:0] lim, input logic ldr);
      logic ok;
      ok = 1'b0;
      if (rgn == RGN_EEPROM) begin
         ok = (a < EEPROM_TOP);
      end else if (rgn == RGN_MAIN && a < MAIN_TOP) begin
         if (ldr) begin
            ok = 1'b1;
         end else begin
            unique case (lim)
               LIMIT_NONE: ok = 1'b0;
               LIMIT_1K:   ok = (a >= LAST_1K);
               LIMIT_2K:   ok = (a >= LAST_2K);
               default:    ok = 1'b1;
            endcase
         end
      end
      return ok;
   endfunction : ifp_allowed

   // Address handed to the array: erase always starts at the sector base.
   function automatic logic [15:0] ifp_array_addr(input logic erase, input logic [15:0] a);
      return erase ? (a & SECTOR_MASK) : a;
   endfunction : ifp_array_addr

   // ************************************************************
   // Registers and wires
   // ************************************************************
   logic [7:0]     addr_lo_r;
   logic [7:0]     addr_hi_r;
   logic [7:0]     region_r;
   logic [7:0]     data_r;
   logic           ctl_boot_r;
   logic           ctl_erase_r;
   logic           ctl_prog_r;
   logic [1:0]     ctl_cmd_r;
   logic           refused_r;
   ifp_state_t     state_r;
   ifp_state_t     state_nxt;
   logic [7:0]     rd_byte;
   logic [15:0]    target_address;
   logic           acc;
   logic           wr_en;
   logic           hit;
   logic           wr_key;
   logic           wr_ctl;
   logic           cmd_try;
   logic           one_op;
   logic           go;
   logic           armed;
   logic           key_load;
   logic           op_done;
   logic [9:0]     idx;

   // ************************************************************
   // APB slave
   // ************************************************************

   // Decode; a write takes effect at the edge where pready is high.
   assign idx    = paddr[11:2];
   assign acc    = psel & penable;
   assign wr_en  = acc & pready & pwrite;
   assign hit    = (idx[9:8] == 2'b00) && (idx[7:0] >= UNLOCK_KEY_IDX) && (idx[7:0] <= STATUS_IDX);
   assign wr_key = wr_en & hit & (idx[7:0] == UNLOCK_KEY_IDX);
   assign wr_ctl = wr_en & hit & (idx[7:0] == PROGRAM_CTRL_IDX);

   // Read mux; the key reads back zero since its value lives in the timer.
   assign rd_byte = (idx[7:0] == TARGET_ADDR_LO_IDX) ? addr_lo_r :
                    (idx[7:0] == TARGET_ADDR_HI_IDX) ? addr_hi_r :
                    (idx[7:0] == REGION_SELECT_IDX)  ? region_r :
                    (idx[7:0] == PROGRAM_DATA_IDX)   ? data_r :
                    (idx[7:0] == PROGRAM_CTRL_IDX)   ? {ctl_boot_r, 1'b0, ctl_erase_r, ctl_prog_r,
                                                        2'b00, ctl_cmd_r} :
                    (idx[7:0] == STATUS_IDX)         ? {5'h00, (state_r == ST_BUSY), refused_r, armed} :
                    REG_RESET;

   // One wait state so that read data and the error flag come from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~hit;
         prdata  <= (acc & ~pready & hit & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ************************************************************
   // Plain data registers
   // ************************************************************

   // Address, region and data registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_lo_r <= REG_RESET;
         addr_hi_r <= REG_RESET;
         region_r  <= REG_RESET;
         data_r    <= REG_RESET;
      end else if (wr_en & hit) begin
         if (idx[7:0] == TARGET_ADDR_LO_IDX) addr_lo_r <= pwdata[7:0];
         if (idx[7:0] == TARGET_ADDR_HI_IDX) addr_hi_r <= pwdata[7:0];
         if (idx[7:0] == REGION_SELECT_IDX)  region_r  <= pwdata[7:0];
         if (idx[7:0] == PROGRAM_DATA_IDX)   data_r    <= pwdata[7:0];
      end
   end

   assign target_address = {addr_hi_r, addr_lo_r};

   // ************************************************************
   // Unlock key
   // ************************************************************

   // Keys below the threshold close the window instead of opening it.
   assign key_load = wr_key;

   ifp_arm_timer u_arm (
      .clk      (pclk),
      .rst_n    (presetn),
      .load     (key_load),
      .load_val ((pwdata[7:0] >= KEY_MIN) ? pwdata[7:0] : REG_RESET),
      .consume  (cmd_try),
      .armed    (armed)
   );

   // ************************************************************
   // Command acceptance
   // ************************************************************

   // Software writes the operation bit first and then ORs in the command
   // code, so both appear in the same written byte; a lone bit is not enough.
   assign cmd_try = wr_ctl & (pwdata[1:0] == CMD_GO) & (state_r == ST_IDLE);
   assign one_op  = pwdata[CTL_ERASE_BIT] ^ pwdata[CTL_PROG_BIT];
   assign go      = cmd_try & armed & one_op
                  & ifp_allowed(region_r, target_address, programmable_region_limit, running_loader);

   // Sticky refusal flag, cleared by writing one; a new refusal wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_r <= 1'b0;
      end else if (cmd_try & ~go) begin
         refused_r <= 1'b1;
      end else if (wr_en & hit & (idx[7:0] == STATUS_IDX) & pwdata[STAT_REFUSE_BIT]) begin
         refused_r <= 1'b0;
      end
   end

   // Control register; the command field clears when the operation ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_boot_r  <= 1'b0;
         ctl_erase_r <= 1'b0;
         ctl_prog_r  <= 1'b0;
         ctl_cmd_r   <= 2'h0;
      end else if (wr_ctl) begin
         ctl_boot_r  <= pwdata[CTL_BOOT_BIT];
         ctl_erase_r <= pwdata[CTL_ERASE_BIT];
         ctl_prog_r  <= pwdata[CTL_PROG_BIT];
         ctl_cmd_r   <= go ? CMD_GO : 2'h0;
      end else if (op_done) begin
         ctl_cmd_r   <= 2'h0;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************

   // Busy from acceptance until the array reports completion.
   assign op_done   = (state_r == ST_BUSY) & flash_done;
   assign state_nxt = go ? ST_BUSY : (op_done ? ST_IDLE : state_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Array request and processor stall; the stall is what lets software
   // skip polling, though it still pads with no-ops after the command.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_req <= 1'b0;
         cpu_stall <= 1'b0;
         flash_cmd <= '0;
      end else if (go) begin
         flash_req       <= 1'b1;
         cpu_stall       <= 1'b1;
         flash_cmd.erase <= pwdata[CTL_ERASE_BIT];
         flash_cmd.eeprom <= (region_r == RGN_EEPROM);
         flash_cmd.addr  <= ifp_array_addr(pwdata[CTL_ERASE_BIT], target_address);
         flash_cmd.wdata <= data_r;
      end else if (op_done) begin
         flash_req <= 1'b0;
         cpu_stall <= 1'b0;
      end
   end

   // ************************************************************
   // Code-read mapping and boot selection
   // ************************************************************

   // Loader ROM is mapped only for code running from it; reserved codes
   // fall back to main flash so instruction fetch never reads garbage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_read_map    <= 2'h0;
         boot_from_loader <= 1'b0;
      end else begin
         boot_from_loader <= ctl_boot_r;
         if (region_r == RGN_UID) begin
            code_read_map <= RGN_UID[1:0];
         end else if (region_r == RGN_EEPROM) begin
            code_read_map <= RGN_EEPROM[1:0];
         end else if (region_r == RGN_LOADER && running_loader) begin
            code_read_map <= RGN_LOADER[1:0];
         end else begin
            code_read_map <= RGN_MAIN[1:0];
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [7:0] since_load_r;
   logic [7:0] key_n_r;

   // Helper: cycles since the last key load and the window it opened.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_load_r <= 8'h00;
         key_n_r      <= 8'h00;
      end else if (key_load) begin
         since_load_r <= 8'h00;
         key_n_r      <= pwdata[7:0];
      end else if (since_load_r != 8'hFF) begin
         since_load_r <= since_load_r + 8'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_key_arms: assert property (wr_key && pwdata[7:0] >= KEY_MIN |=> armed)
      else $error("Key at or above threshold did not arm.");
   a_key_low: assert property (wr_key && pwdata[7:0] < KEY_MIN |=> !armed)
      else $error("Key below threshold armed the block.");
   a_window_len: assert property (armed && key_n_r >= KEY_MIN |-> since_load_r < key_n_r)
      else $error("Arming window outlived its key value.");
   a_window_end: assert property ($fell(armed) && !$past(cmd_try) && !$past(key_load)
                                  |-> since_load_r == key_n_r)
      else $error("Arming window closed at the wrong cycle.");
   a_region_legal: assert property ($rose(flash_req) |-> $past(region_r) == RGN_MAIN
                                    || $past(region_r) == RGN_EEPROM)
      else $error("Operation started on a read-only region.");
   a_limit_kept: assert property ($rose(flash_req) |-> ifp_allowed($past(region_r),
                      $past(target_address), $past(programmable_region_limit), $past(running_loader)))
      else $error("Operation outside the programmable region.");
   a_erase_align: assert property (flash_req && flash_cmd.erase |-> flash_cmd.addr[8:0] == 9'h000)
      else $error("Erase address not sector aligned.");
   a_prog_data: assert property (go && !pwdata[CTL_ERASE_BIT] |=> flash_req && !flash_cmd.erase
                                 && flash_cmd.wdata == $past(data_r))
      else $error("Program request lost its data byte.");
   a_unarmed_ignored: assert property (cmd_try && !armed |=> !flash_req && state_r == ST_IDLE)
      else $error("Command accepted while not armed.");
   a_stall_span: assert property (state_r == ST_BUSY |-> cpu_stall && flash_req)
      else $error("Stall dropped before completion.");
   a_stall_release: assert property (op_done |=> !cpu_stall && !flash_req)
      else $error("Stall held after completion.");

   c_erase: cover property (go && pwdata[CTL_ERASE_BIT] ##[1:20] op_done);
   c_program: cover property (go && pwdata[CTL_PROG_BIT] ##[1:20] op_done);
   c_timeout: cover property ($fell(armed) && !$past(cmd_try));
   c_refused: cover property ($rose(refused_r));

endmodule : ifp_programmer
`default_nettype wire

// *** logic/ifp_pkg.sv ***
// Package of constants and types for the in-application flash programmer.
package ifp_pkg;

   // ************************************************************
   // Register indices; the byte address is four times the index.
   // ************************************************************
   localparam logic [7:0] UNLOCK_KEY_IDX     = 8'hF1;
   localparam logic [7:0] TARGET_ADDR_LO_IDX = 8'hF2;
   localparam logic [7:0] TARGET_ADDR_HI_IDX = 8'hF3;
   localparam logic [7:0] REGION_SELECT_IDX  = 8'hF4;
   localparam logic [7:0] PROGRAM_DATA_IDX   = 8'hF5;
   localparam logic [7:0] PROGRAM_CTRL_IDX   = 8'hF6;
   localparam logic [7:0] STATUS_IDX         = 8'hF7;

   // ************************************************************
   // Field positions, values and reset values.
   // ************************************************************
   localparam int         CTL_BOOT_BIT   = 7;
   localparam int         CTL_ERASE_BIT  = 5;
   localparam int         CTL_PROG_BIT   = 4;
   localparam logic [1:0] CMD_GO         = 2'h2;
   localparam logic [7:0] KEY_MIN        = 8'h40;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam int         STAT_ARMED_BIT = 0;
   localparam int         STAT_REFUSE_BIT = 1;
   localparam int         STAT_BUSY_BIT  = 2;

   // Region select codes.
   localparam logic [7:0] RGN_MAIN   = 8'h00;
   localparam logic [7:0] RGN_UID    = 8'h01;
   localparam logic [7:0] RGN_EEPROM = 8'h02;
   localparam logic [7:0] RGN_LOADER = 8'h03;

   // Address limits of the arrays and of the programmable-region option.
   localparam logic [15:0] MAIN_TOP    = 16'h8000;
   localparam logic [15:0] EEPROM_TOP  = 16'h1800;
   localparam logic [15:0] LAST_1K     = 16'h7C00;
   localparam logic [15:0] LAST_2K     = 16'h7800;
   localparam logic [15:0] SECTOR_MASK = 16'hFE00;
   localparam logic [1:0]  LIMIT_NONE  = 2'h0;
   localparam logic [1:0]  LIMIT_1K    = 2'h1;
   localparam logic [1:0]  LIMIT_2K    = 2'h2;

   // Controller states, Gray coded.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01
   } ifp_state_t;

   // One request to the flash array.
   typedef struct packed {
      logic        erase;
      logic        eeprom;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ifp_flash_cmd_t;

endpackage : ifp_pkg

// *** logic/ifp_arm_timer.sv ***
// Arming window counter for the unlock key.
`timescale 1ns/100ps
`default_nettype none
module ifp_arm_timer
   import ifp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   input  wire logic       consume,
   output var  logic       armed
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   // ************************************************************
   // Countdown
   // ************************************************************

   // A load opens a window of load_val cycles; a command or expiry closes it.
   assign cnt_nxt = load     ? load_val :
                    consume  ? REG_RESET :
                    (cnt_r != REG_RESET) ? cnt_r - 8'h01 : cnt_r;

   // Window register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Armed while any cycles of the window remain.
   assign armed = (cnt_r != REG_RESET);

endmodule : ifp_arm_timer
`default_nettype wire

// *** bench/in_app_flash_programmer_tb.sv ***
// Self-checking testbench of the in-application flash programmer.
`timescale 1ns/100ps
`default_nettype none
module in_app_flash_programmer_tb
   import ifp_pkg::*;
;

   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0000_0000;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [1:0]     limit = 2'h3;
   logic           running_loader = 1'b0;
   logic           flash_done = 1'b0;
   logic           flash_req;
   ifp_flash_cmd_t flash_cmd;
   logic           cpu_stall;
   logic [1:0]     code_read_map;
   logic           boot_from_loader;
   logic [32:0]    exp_q[$];
   logic [32:0]    note;
   logic [31:0]    seed = 32'd69;
   logic [7:0]     d;
   int             err_count = 0;
   int             samples_checked = 0;

   // Clock of 100 MHz.
   always #5 pclk = ~pclk;

   ifp_programmer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .programmable_region_limit(limit), .running_loader(running_loader), .flash_done(flash_done),
      .flash_req(flash_req), .flash_cmd(flash_cmd), .cpu_stall(cpu_stall), .code_read_map(code_read_map),
      .boot_from_loader(boot_from_loader));

   // ************************************************************
   // Helpers.
   // ************************************************************
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] v);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, v};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, v);
   endtask : wr

   // A read notes its expected word and error flag for the monitor.
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic err = 1'b0);
      exp_q.push_back({err, 24'h000000, e});
      apb(1'b0, idx, 8'h00);
   endtask : rd

   // Address, key, operation bit alone, then bit and command code together,
   // followed by the pad of idle cycles that software must leave.
   task automatic cmd(input logic [15:0] a, input logic [7:0] c);
      wr(TARGET_ADDR_HI_IDX, a[15:8]);
      wr(TARGET_ADDR_LO_IDX, a[7:0]);
      wr(UNLOCK_KEY_IDX, 8'hF0);
      wr(PROGRAM_CTRL_IDX, c & 8'hF0);
      wr(PROGRAM_CTRL_IDX, c);
      repeat (12) @(posedge pclk);
   endtask : cmd

   // The array reports completion; request and stall drop one cycle later.
   task automatic done_pulse();
      flash_done <= 1'b1;
      @(posedge pclk);
      flash_done <= 1'b0;
      @(posedge pclk);
      chk(flash_req, 1'b0);
      chk(cpu_stall, 1'b0);
   endtask : done_pulse

   task automatic finish_test();
      $display("checks %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // Read monitor: each completed read is matched against the oldest note.
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("unexpected at %0t: read with no note", $time);
         end else begin
            note = exp_q.pop_front();
            chk({31'h0, pslverr}, {31'h0, note[32]});
            chk(prdata, note[31:0]);
         end
      end
   end

   // Watchdog; the whole run needs well under 2000 cycles.
   initial begin
      #200000;
      err_count++;
      finish_test();
   end

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 241; i <= 246; i++) rd(i[7:0], REG_RESET);
      rd(8'h10, 8'h00, 1'b1);
      d = rnd();
      wr(TARGET_ADDR_LO_IDX, d);
      rd(TARGET_ADDR_LO_IDX, d);
      wr(TARGET_ADDR_HI_IDX, ~d);
      rd(TARGET_ADDR_HI_IDX, ~d);
      wr(PROGRAM_DATA_IDX, d ^ 8'h5A);
      rd(PROGRAM_DATA_IDX, d ^ 8'h5A);
      // Code read mapping follows the region one cycle after the write.
      for (int r = 0; r < 3; r++) begin
         wr(REGION_SELECT_IDX, r[7:0]);
         @(posedge pclk);
         chk(code_read_map, r);
      end
      // A reserved region code falls back to main flash for code reads.
      wr(REGION_SELECT_IDX, 8'h05);
      @(posedge pclk);
      chk(code_read_map, 2'h0);
      running_loader <= 1'b1;
      wr(REGION_SELECT_IDX, RGN_LOADER);
      @(posedge pclk);
      chk(code_read_map, 2'h3);
      running_loader <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(code_read_map, 2'h0);
      wr(PROGRAM_CTRL_IDX, 8'h80);
      @(posedge pclk);
      chk(boot_from_loader, 1'b1);
      rd(PROGRAM_CTRL_IDX, 8'h80);
      wr(PROGRAM_CTRL_IDX, 8'h00);
      // Sector erase in main flash, aligned to 512 bytes.
      wr(REGION_SELECT_IDX, RGN_MAIN);
      cmd(16'h1234, 8'h22);
      chk(flash_req, 1'b1);
      chk(cpu_stall, 1'b1);
      chk({flash_cmd.erase, flash_cmd.eeprom, flash_cmd.addr}, {2'b10, 16'h1200});
      rd(STATUS_IDX, 8'h04);
      done_pulse();
      rd(STATUS_IDX, 8'h00);
      // Byte program into the EEPROM array.
      wr(REGION_SELECT_IDX, RGN_EEPROM);
      d = rnd();
      wr(PROGRAM_DATA_IDX, d);
      cmd(16'h0105, 8'h12);
      chk(flash_cmd, {2'b01, 16'h0105, d});
      done_pulse();
      // The unique ID area refuses programming.
      wr(REGION_SELECT_IDX, RGN_UID);
      cmd(16'h0010, 8'h12);
      chk(flash_req, 1'b0);
      rd(STATUS_IDX, 8'h02);
      wr(STATUS_IDX, 8'h02);
      // Limit of the last 1K: one byte below refused, the boundary accepted.
      limit <= LIMIT_1K;
      wr(REGION_SELECT_IDX, RGN_MAIN);
      cmd(16'h7BFF, 8'h12);
      chk(flash_req, 1'b0);
      wr(STATUS_IDX, 8'h02);
      cmd(16'h7C00, 8'h12);
      chk(flash_req, 1'b1);
      done_pulse();
      // No programmable region refuses all of main flash, unless code runs from the loader.
      limit <= LIMIT_NONE;
      cmd(16'h7C00, 8'h12);
      chk(flash_req, 1'b0);
      wr(STATUS_IDX, 8'h02);
      running_loader <= 1'b1;
      cmd(16'h0400, 8'h12);
      chk(flash_req, 1'b1);
      done_pulse();
      running_loader <= 1'b0;
      // A reserved command code starts nothing and keeps the key.
      limit <= 2'h3;
      cmd(16'h0200, 8'h11);
      chk(flash_req, 1'b0);
      rd(STATUS_IDX, 8'h01);
      // Both operation bits at once are refused and use up the key.
      wr(PROGRAM_CTRL_IDX, 8'h32);
      chk(flash_req, 1'b0);
      rd(STATUS_IDX, 8'h02);
      wr(STATUS_IDX, 8'h02);
      // A key of 0x40 expires after 64 cycles; a late command is refused.
      wr(UNLOCK_KEY_IDX, KEY_MIN);
      rd(STATUS_IDX, 8'h01);
      repeat (70) @(posedge pclk);
      rd(STATUS_IDX, 8'h00);
      wr(PROGRAM_CTRL_IDX, 8'h22);
      chk(flash_req, 1'b0);
      rd(STATUS_IDX, 8'h02);
      repeat (3) @(posedge pclk);
      chk(exp_q.size(), 0);
      finish_test();
   end
endmodule : in_app_flash_programmer_tb
`default_nettype wire
